// file: host_cpu_model.sv
// host cpu model: axi4-lite master for the registers and pixel word writer
// assumes: tasks are called by the bench one at a time, single clock aclk
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  input wire logic aclk,
  output logic [3:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [3:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic wr_valid,
  output logic [31:0] wr_data
);
  // ****************************************
  // idle state
  // ****************************************
  // whole words only, so strobes stay full
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, wr_valid, wr_data} = '0;
    s_axi_wstrb = 4'hf;
  end
  // ****************************************
  // bus cycles
  // ****************************************
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    // released payload is inverted so a stale value cannot pass
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read: rready held until the answer is sampled
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one aligned word per write, depth already encoded by the host
  // unsupported codes are sent only when the bench asks for them
  task automatic px_wr(input logic [31:0] d);
    @(posedge aclk);
    wr_valid <= 1'b1;
    wr_data <= d;
    @(posedge aclk);
    wr_valid <= 1'b0;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

// file: lfb_params.svh
// constants for the direct pixel window formatter
// assumes: included by bare name from the formatter module and its bench
// Function
// - word swap skipped for formats 4 and 5
// - swizzle exchanges outer and inner byte lanes
// - write swizzle bit never touches reads
// - order: swizzle, word swap, lane select
// - reads take origin from access bit
// - bypass writes access origin, pipeline render origin
// - origin bit 0 top, 1 bottom
// - w gets 16-bit depth in top fraction
// - w select ignored for bypass writes
// - 5-6-5 lanes; orders 1,3 swap red/blue
// - x-5-5-5 field placement by lane order
// - 1-5-5-5 alpha bit replicated to eight
// - format 4 is aligned 24-bit colour
// - 8-8-8-8 alpha position by lane order
// - missing depth/alpha from constant register
// - format 15 colour from constant colour
// - format 15 swap: upper is left depth
// - reads return two pixels, depth select 2
// - pipeline enable 0 bypasses, 1 processes
// - depth/colour halves placed by word swap
// - read word swap orders the pixels
`ifndef LFB_PARAMS_SVH
`define LFB_PARAMS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_ACCESS_CTRL 4'h0
`define ADDR_RENDER_CTRL 4'h4
`define ADDR_CONST_COLOUR 4'h8
`define ADDR_CONST_DEPTH_ALPHA 4'hc
// ****************************************
// access control fields
// ****************************************
`define AC_FMT_HI 3
`define AC_FMT_LO 0
`define AC_RDSEL_HI 7
`define AC_RDSEL_LO 6
`define AC_PIPE_EN 8
`define AC_LANE_HI 10
`define AC_LANE_LO 9
`define AC_WSWAP 11
`define AC_SWIZZLE 12
`define AC_YORG 13
`define AC_WSEL 14
`define AC_RSWAP 15
`define RC_YORG 17
`define RDSEL_DEPTH 2'h2
`define RESET_ZERO 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: lfb_pixel_format_unpacker.sv
// direct pixel window formatter: registers over axi4-lite, write unpack, read pack
// assumes: single clock, host writes arrive as wr_valid with 32-bit data
`timescale 1ns/10ps
`default_nettype none
`include "lfb_params.svh"
module lfb_pixel_format_unpacker
  import lfb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host pixel write
  input wire logic wr_valid,
  input wire logic [31:0] wr_data,
  // formatted pixel out (registered)
  output logic px_valid,
  output logic px_pipeline,
  output logic [23:0] px_rgb0,
  output logic [7:0] px_alpha0,
  output logic [15:0] px_depth0,
  output logic [23:0] px_rgb1,
  output logic [7:0] px_alpha1,
  output logic [15:0] px_depth1,
  output logic px_two,
  output logic px_wr_colour,
  output logic px_wr_depth,
  output logic [47:0] px_w,
  output logic px_y_bottom,
  output logic px_discard,
  // host pixel read
  input wire logic rd_valid,
  input wire logic [15:0] rd_left_colour,
  input wire logic [15:0] rd_right_colour,
  input wire logic [15:0] rd_left_depth,
  input wire logic [15:0] rd_right_depth,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic rd_y_bottom,
  output logic rd_depth_sel
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] access_q; // frame_buffer_access_control
  logic [31:0] render_q; // render_pixel_control
  logic [31:0] colour_q; // const_fill_colour
  logic [31:0] zacol_q; // constant depth/alpha
  wr_state_t wst_q;
  logic aw_got_q, w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_bad; // combinational: latched address decodes to no register

  // address and data may arrive in either order; both latched then committed
  assign s_axi_awready = (wst_q == WR_IDLE) && !aw_got_q;
  assign s_axi_wready = (wst_q == WR_IDLE) && !w_got_q;

  // write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= WR_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= `RESET_ZERO;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      unique case (wst_q)
        WR_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
          end
          if (aw_got_q && w_got_q) begin
            // both halves held: commit and answer
            wst_q <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wst_q <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // unmapped write address gets an error response
  always_comb begin
    wr_bad = !(aw_addr_q == `ADDR_ACCESS_CTRL || aw_addr_q == `ADDR_RENDER_CTRL ||
                 aw_addr_q == `ADDR_CONST_COLOUR || aw_addr_q == `ADDR_CONST_DEPTH_ALPHA);
  end

  // register stores with byte strobes, one loop over lanes
  logic commit;
  assign commit = (wst_q == WR_IDLE) && aw_got_q && w_got_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          access_q[gi*8 +: 8] <= 8'h00;
          render_q[gi*8 +: 8] <= 8'h00;
          colour_q[gi*8 +: 8] <= 8'h00;
          zacol_q[gi*8 +: 8] <= 8'h00;
        end else if (commit && w_strb_q[gi]) begin
          if (aw_addr_q == `ADDR_ACCESS_CTRL) access_q[gi*8 +: 8] <= w_data_q[gi*8 +: 8];
          if (aw_addr_q == `ADDR_RENDER_CTRL) render_q[gi*8 +: 8] <= w_data_q[gi*8 +: 8];
          if (aw_addr_q == `ADDR_CONST_COLOUR) colour_q[gi*8 +: 8] <= w_data_q[gi*8 +: 8];
          if (aw_addr_q == `ADDR_CONST_DEPTH_ALPHA) zacol_q[gi*8 +: 8] <= w_data_q[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // read channel: one-cycle answer after address accepted
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RESET_ZERO;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `ADDR_ACCESS_CTRL: s_axi_rdata <= access_q;
        `ADDR_RENDER_CTRL: s_axi_rdata <= render_q;
        `ADDR_CONST_COLOUR: s_axi_rdata <= colour_q;
        `ADDR_CONST_DEPTH_ALPHA: s_axi_rdata <= zacol_q;
        default: begin
          s_axi_rdata <= `RESET_ZERO;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // write formatting
  // ****************************************
  logic [3:0] fmt;
  logic [1:0] lane;
  logic pipe_en;
  logic is32;
  logic [31:0] wd;
  assign fmt = access_q[`AC_FMT_HI:`AC_FMT_LO];
  assign lane = access_q[`AC_LANE_HI:`AC_LANE_LO];
  assign pipe_en = access_q[`AC_PIPE_EN];
  // formats 4 and 5 never get the word swap
  assign is32 = (fmt == FMT_888) || (fmt == FMT_8888);

  lfb_swizzle u_wswz (
    .din(wr_data),
    .swizzle(access_q[`AC_SWIZZLE]),
    .wswap(access_q[`AC_WSWAP] && !is32),
    .dout(wd)
  );

  // colour half: without swap the colour sits low for z+colour formats
  logic [1:0] kind;
  logic [23:0] rgb_lo, rgb_hi;
  logic [7:0] a_lo, a_hi;
  logic ha_lo, ha_hi;
  always_comb begin
    unique case (fmt)
      FMT_X555, FMT_ZX555: kind = 2'h1;
      FMT_1555, FMT_Z1555: kind = 2'h2;
      default: kind = 2'h0;
    endcase
  end
  lfb_unpack16 u_lo (
    .px(wd[15:0]), .kind(kind), .lane(lane),
    .rgb(rgb_lo), .alpha(a_lo), .has_alpha(ha_lo)
  );
  lfb_unpack16 u_hi (
    .px(wd[31:16]), .kind(kind), .lane(lane),
    .rgb(rgb_hi), .alpha(a_hi), .has_alpha(ha_hi)
  );

  // after the word swap the left pixel/colour is in the low half for all formats but 4 and 5
  logic [23:0] c0_d, c1_d;
  logic [7:0] a0_d, a1_d;
  logic [15:0] z0_d, z1_d;
  logic two_d, wcol_d, wdep_d, bad_d;
  logic [23:0] rgb32;
  logic [7:0] a32;
  always_comb begin
    // format 4/5 lanes
    if (lane[1]) begin
      rgb32 = lane[0] ? {wd[15:8], wd[23:16], wd[31:24]} : wd[31:8];
      a32 = wd[7:0];
    end else begin
      rgb32 = lane[0] ? {wd[7:0], wd[15:8], wd[23:16]} : wd[23:0];
      a32 = wd[31:24];
    end
    // defaults: constant fill of missing parts
    c0_d = rgb_lo;
    c1_d = rgb_hi;
    a0_d = zacol_q[31:24];
    a1_d = zacol_q[31:24];
    z0_d = zacol_q[15:0];
    z1_d = zacol_q[15:0];
    two_d = 1'b0;
    wcol_d = 1'b1;
    wdep_d = pipe_en;
    bad_d = 1'b0;
    unique case (fmt)
      FMT_565, FMT_X555, FMT_1555: begin
        two_d = 1'b1;
        if (ha_lo) a0_d = a_lo;
        if (ha_hi) a1_d = a_hi;
      end
      FMT_888: c0_d = rgb32;
      FMT_8888: begin
        c0_d = rgb32;
        a0_d = a32;
      end
      FMT_Z565, FMT_ZX555, FMT_Z1555: begin
        z0_d = wd[31:16];
        wdep_d = 1'b1;
        if (ha_lo) a0_d = a_lo;
      end
      FMT_ZZ: begin
        // swapped word puts left depth low, matching unswapped order
        two_d = 1'b1;
        z0_d = wd[15:0];
        z1_d = wd[31:16];
        c0_d = colour_q[23:0];
        c1_d = colour_q[23:0];
        wcol_d = pipe_en;
        wdep_d = 1'b1;
      end
      default: begin
        // formats the host must not use are dropped
        bad_d = 1'b1;
        wcol_d = 1'b0;
        wdep_d = 1'b0;
      end
    endcase
  end

  // registered pixel outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      px_valid <= 1'b0;
      px_discard <= 1'b0;
      px_pipeline <= 1'b0;
      px_rgb0 <= 24'h000000;
      px_rgb1 <= 24'h000000;
      px_alpha0 <= 8'h00;
      px_alpha1 <= 8'h00;
      px_depth0 <= 16'h0000;
      px_depth1 <= 16'h0000;
      px_two <= 1'b0;
      px_wr_colour <= 1'b0;
      px_wr_depth <= 1'b0;
      px_w <= 48'h000000000000;
      px_y_bottom <= 1'b0;
    end else begin
      px_valid <= wr_valid && !bad_d;
      px_discard <= wr_valid && bad_d;
      px_pipeline <= pipe_en;
      px_rgb0 <= c0_d;
      px_rgb1 <= c1_d;
      px_alpha0 <= a0_d;
      px_alpha1 <= a1_d;
      px_depth0 <= z0_d;
      px_depth1 <= z1_d;
      px_two <= two_d;
      px_wr_colour <= wcol_d;
      px_wr_depth <= wdep_d;
      // w fraction top bits only, pipeline writes only
      if (pipe_en) begin
        px_w <= {16'h0000, access_q[`AC_WSEL] ? zacol_q[15:0] : z0_d, 16'h0000};
      end else begin
        px_w <= 48'h000000000000;
      end
      // origin source and sense
      px_y_bottom <= pipe_en ? render_q[`RC_YORG] : access_q[`AC_YORG];
    end
  end

  // ****************************************
  // read packing
  // ****************************************
  logic [15:0] rl, rr;
  always_comb begin
    // depth/alpha buffer when read select is 2
    rl = (access_q[`AC_RDSEL_HI:`AC_RDSEL_LO] == `RDSEL_DEPTH) ? rd_left_depth : rd_left_colour;
    rr = (access_q[`AC_RDSEL_HI:`AC_RDSEL_LO] == `RDSEL_DEPTH) ? rd_right_depth : rd_right_colour;
  end
  // read path ignores the write swizzle bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_done <= 1'b0;
      rd_data <= `RESET_ZERO;
      rd_y_bottom <= 1'b0;
      rd_depth_sel <= 1'b0;
    end else begin
      rd_done <= rd_valid;
      rd_data <= access_q[`AC_RSWAP] ? {rl, rr} : {rr, rl};
      rd_y_bottom <= access_q[`AC_YORG];
      rd_depth_sel <= access_q[`AC_RDSEL_HI:`AC_RDSEL_LO] == `RDSEL_DEPTH;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_wr_discard: assert property (@(posedge aclk) disable iff (!aresetn)
    px_discard |-> !px_valid) else $error("discarded write marked valid");
  a_read_origin: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_done |-> rd_y_bottom == $past(access_q[`AC_YORG])) else $error("read origin wrong");
  a_w_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (px_valid && !px_pipeline) |-> px_w == 48'h000000000000) else $error("w set on bypass");
  a_w_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    px_valid |-> (px_w[15:0] == 16'h0000 && px_w[47:32] == 16'h0000)) else $error("w low bits");
  a_wr_origin: assert property (@(posedge aclk) disable iff (!aresetn)
    (px_valid && !px_pipeline) |-> px_y_bottom == $past(access_q[`AC_YORG]))
    else $error("write origin wrong");
  a_rd_swap: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_valid && !access_q[`AC_RSWAP] |=> rd_data[15:0] == $past(rl)) else $error("read order");
  a_zz_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_valid && fmt == FMT_ZZ) |=> px_depth0 == $past(wd[15:0])) else $error("zz left depth");
  a_bresp_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    commit |=> s_axi_bvalid) else $error("no write response");
endmodule
`default_nettype wire

// file: lfb_pixel_format_unpacker_test.sv
// bench for the pixel window formatter, with a reference model of the formats
// assumes: host_cpu_model drives the bus and pixel writes, bench drives reads
`timescale 1ns/10ps
`default_nettype none
`include "lfb_params.svh"
module lfb_pixel_format_unpacker_test;
  logic aclk, aresetn, wr_valid, rd_valid, rd_done, rd_y_bottom, rd_depth_sel;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, wr_data, rd_data, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic px_valid, px_pipeline, px_two, px_wr_colour, px_wr_depth, px_y_bottom, px_discard;
  logic [23:0] px_rgb0, px_rgb1;
  logic [7:0] px_alpha0, px_alpha1;
  logic [15:0] px_depth0, px_depth1, rd_left_colour, rd_right_colour;
  logic [15:0] rd_left_depth, rd_right_depth;
  logic [47:0] px_w;
  logic [31:0] rv [4]; // model of the four registers
  logic [31:0] mk [4] = '{32'h0000_ffff, 32'h0002_0000, 32'h00ff_ffff, 32'hff00_ffff};
  int mismatches, n_checks, cycles;
  lfb_pixel_format_unpacker uut (.*);
  host_cpu_model host (.*);
  // ****************************************
  // clock, timeout, report
  // ****************************************
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  // run needs under two thousand cycles; the ceiling leaves ample margin
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic note(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, e, input string m);
    note(g === e, m);
  endtask
  task automatic cmp_px(input logic [47:0] g, e, input string m);
    note(g === e, m);
  endtask
  task automatic cmp_rd(input logic [31:0] g, e, input string m);
    note(g === e, m);
  endtask
  // lfsr stepped a full word per call
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // ****************************************
  // reference model
  // ****************************************
  // 16-bit colour half: k 0 = 5-6-5, 1 = x-5-5-5, 2 = 1-5-5-5; returns {alpha, rgb}
  function automatic logic [31:0] c16(input logic [15:0] p, input int k, ln, input logic [7:0] ain);
    logic [7:0] x, g, y, a;
    a = ain;
    if (k == 0) {x, g, y} = {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
    else if (ln < 2) {x, g, y} = {p[14:10], 3'h0, p[9:5], 3'h0, p[4:0], 3'h0};
    else {x, g, y} = {p[15:11], 3'h0, p[10:6], 3'h0, p[5:1], 3'h0};
    if (k == 2) a = {8{(ln < 2) ? p[15] : p[0]}};
    return (ln % 2 == 1) ? {a, y, g, x} : {a, x, g, y};
  endfunction
  // one host word through the design, checked against the model
  task automatic px_check(input logic [31:0] hd);
    logic [31:0] s, d;
    logic [23:0] r0, r1;
    logic [7:0] a0, aa, ta;
    logic [15:0] z0, z1;
    logic [3:0] f;
    logic pipe, ok, two, hasa;
    int ln;
    f = rv[0][3:0];
    ln = rv[0][10:9];
    pipe = rv[0][8];
    s = rv[0][12] ? {hd[7:0], hd[15:8], hd[23:16], hd[31:24]} : hd;
    d = (rv[0][11] && f != 4'h4 && f != 4'h5) ? {s[15:0], s[31:16]} : s;
    {a0, z0, z1, r0, r1, two, ok} = {rv[3][31:24], rv[3][15:0], rv[3][15:0], 48'h0, 2'b01};
    case (f)
      4'h0, 4'h1, 4'h2: begin
        {a0, r0} = c16(d[15:0], f, ln, a0);
        {aa, r1} = c16(d[31:16], f, ln, a0);
        two = 1'b1;
      end
      4'h4, 4'h5: begin
        if (ln < 2) {ta, r0} = d;
        else {r0, ta} = d;
        if (ln % 2 == 1) r0 = {r0[7:0], r0[15:8], r0[23:16]};
        if (f == 4'h5) a0 = ta;
      end
      4'hc, 4'hd, 4'he: begin
        {a0, r0} = c16(d[15:0], f - 4'hc, ln, a0);
        z0 = d[31:16];
      end
      4'hf: {r0, z1, z0, two} = {rv[2][23:0], d, 1'b1};
      default: ok = 1'b0; // codes with no defined layout
    endcase
    hasa = pipe || f == 4'h2 || f == 4'h5 || f == 4'he;
    host.px_wr(hd);
    @(negedge aclk);
    cmp_px(px_discard, !ok, "discard flag");
    cmp_px(px_valid, ok, "valid flag");
    if (ok) begin
      if (f != 4'hf || pipe) cmp_px(px_rgb0, r0, "colour 0");
      if (f < 4'h3) cmp_px(px_rgb1, r1, "colour 1");
      if (f < 4'h3 && hasa) cmp_px(px_alpha1, aa, "alpha 1");
      if (hasa) cmp_px(px_alpha0, a0, "alpha 0");
      if (pipe || f > 4'hb) cmp_px(px_depth0, z0, "depth 0");
      if (f == 4'hf) cmp_px(px_depth1, z1, "depth 1");
      cmp_px(px_two, two, "pixel count");
      cmp_px(px_w, pipe ? {16'h0, rv[0][14] ? rv[3][15:0] : z0, 16'h0} : 48'h0, "w");
      cmp_px(px_y_bottom, pipe ? rv[1][17] : rv[0][13], "y origin");
      cmp_px(px_pipeline, pipe, "pipeline flag");
      if (!pipe) cmp_px({px_wr_colour, px_wr_depth}, {f != 4'hf, f > 4'hb}, "buffers");
    end
  endtask
  // read of two stored pixels; swizzle bit is random and must not matter
  task automatic rd_check();
    logic [15:0] lc, rc, ld, rdp, l, r;
    logic sel;
    {lc, rc} = rnd();
    {ld, rdp} = rnd();
    @(posedge aclk);
    {rd_valid, rd_left_colour, rd_right_colour, rd_left_depth, rd_right_depth} <= {1'b1, lc, rc, ld, rdp};
    @(posedge aclk);
    {rd_valid, rd_left_colour, rd_right_colour, rd_left_depth, rd_right_depth} <= {1'b0, ~lc, ~rc, ~ld, ~rdp};
    sel = rv[0][7:6] == `RDSEL_DEPTH;
    l = sel ? ld : lc;
    r = sel ? rdp : rc;
    @(negedge aclk);
    cmp_rd(rd_data, rv[0][15] ? {l, r} : {r, l}, "read data");
    cmp_rd({rd_done, rd_depth_sel, rd_y_bottom}, {1'b1, sel, rv[0][13]}, "read flags");
  endtask
  // ****************************************
  // register access
  // ****************************************
  task automatic reg_wr(input int i, input logic [31:0] v);
    logic [1:0] r;
    host.axi_wr(4'(i * 4), v, r);
    cmp_reg(r, `RESP_OKAY, "write response");
    rv[i] = v;
  endtask
  task automatic reg_rd(input int i);
    logic [1:0] r;
    logic [31:0] d;
    host.axi_rd(4'(i * 4), d, r);
    cmp_reg(r, `RESP_OKAY, "read response");
    cmp_reg(d & mk[i], rv[i] & mk[i], "register value");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    {aresetn, rd_valid, rd_left_colour, rd_right_colour, rd_left_depth, rd_right_depth} = '0;
    seed = 32'h501c;
    rv = '{default: `RESET_ZERO};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then write and read back
    for (int i = 0; i < 4; i++) reg_rd(i);
    for (int i = 1; i < 4; i++) begin
      reg_wr(i, rnd());
      reg_rd(i);
    end
    // unmapped address refused and leaves the access register alone
    host.axi_rd(4'h2, d, r);
    cmp_reg(r, `RESP_SLVERR, "unmapped read response");
    cmp_reg(d, 32'h0, "unmapped read data");
    host.axi_wr(4'h2, rnd(), r);
    cmp_reg(r, `RESP_SLVERR, "unmapped write");
    reg_rd(0);
    // every format and lane order, other control bits random
    for (int i = 0; i < 192; i++) begin
      if (i % 64 == 0) reg_wr(1, rnd());
      reg_wr(0, (rnd() & 32'h0000_f9f0) | 32'((i / 16 % 4) * 512 + i % 16));
      px_check(rnd());
    end
    // mid-run reset while the bus is idle clears the whole map
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rv = '{default: `RESET_ZERO};
    for (int i = 0; i < 4; i++) reg_rd(i);
    // reads under each buffer select
    for (int i = 0; i < 16; i++) begin
      reg_wr(0, (rnd() & 32'h0000_ff3f) | 32'((i % 4) * 64));
      rd_check();
    end
    end_sim();
  end
endmodule
`default_nettype wire

// file: lfb_pkg.sv
// types shared by the pixel window formatter
// assumes: compiled before all modules
package lfb_pkg;
  // write formats
  typedef enum logic [3:0] {
    FMT_565 = 4'h0, FMT_X555 = 4'h1, FMT_1555 = 4'h2, FMT_888 = 4'h4,
    FMT_8888 = 4'h5, FMT_Z565 = 4'hc, FMT_ZX555 = 4'hd, FMT_Z1555 = 4'he,
    FMT_ZZ = 4'hf
  } wr_format_t;
  // bus write handshake state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00, WR_RESP = 2'b01
  } wr_state_t;
endpackage

// file: lfb_swizzle.sv
// byte swizzle and 16-bit word swap of one host word
// assumes: purely combinational, fed from host data
`timescale 1ns/10ps
`default_nettype none
module lfb_swizzle (
  input wire logic [31:0] din,
  input wire logic swizzle,
  input wire logic wswap,
  output logic [31:0] dout
);
  logic [31:0] sw;
  // swizzle first, then swap on the swizzled word
  always_comb begin
    sw = swizzle ? {din[7:0], din[15:8], din[23:16], din[31:24]} : din;
    dout = wswap ? {sw[15:0], sw[31:16]} : sw;
  end
endmodule
`default_nettype wire

// file: lfb_unpack16.sv
// unpacks one 16-bit colour half into 8-bit rgb and alpha
// assumes: kind 0 = 5-6-5, 1 = x-5-5-5, 2 = 1-5-5-5
`timescale 1ns/10ps
`default_nettype none
module lfb_unpack16 (
  input wire logic [15:0] px,
  input wire logic [1:0] kind,
  input wire logic [1:0] lane,
  output logic [23:0] rgb,
  output logic [7:0] alpha,
  output logic has_alpha
);
  logic [4:0] c_hi;
  logic [5:0] c_mid;
  logic [4:0] c_lo;
  always_comb begin
    c_hi = px[15:11];
    c_mid = px[10:5];
    c_lo = px[4:0];
    alpha = 8'h00;
    has_alpha = 1'b0;
    if (kind == 2'h0) begin
      // 5-6-5 ignores the upper lane bit
      c_hi = px[15:11];
    end else if (!lane[1]) begin
      // bit 15 unused or alpha
      c_hi = px[14:10];
      c_mid = {px[9:5], 1'b0};
      c_lo = px[4:0];
      alpha = {8{px[15]}};
    end else begin
      c_hi = px[15:11];
      c_mid = {px[10:6], 1'b0};
      c_lo = px[5:1];
      alpha = {8{px[0]}};
    end
    if (kind == 2'h2) begin
      has_alpha = 1'b1;
    end
    // expand to 8 bits; lane orders 1 and 3 swap red and blue
    if (lane[0]) begin
      rgb = {c_lo, 3'h0, c_mid, 2'h0, c_hi, 3'h0};
    end else begin
      rgb = {c_hi, 3'h0, c_mid, 2'h0, c_lo, 3'h0};
    end
  end
endmodule
`default_nettype wire
